/* hw/lrco_pkg.sv */
// Constants and types for the low rate clock oscillator control block
package lrco_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int LRCO_SYS_CLK_PERIOD_NS = 40;
    // Encode periods longer than this count as a low rate (5 MSPS)
    localparam int LRCO_LOW_RATE_PERIOD_NS = 200;
    localparam logic [3:0] LRCO_LOW_RATE_CYCLES =
        4'(LRCO_LOW_RATE_PERIOD_NS / LRCO_SYS_CLK_PERIOD_NS);

    // ==========================================================
    // Serial port framing
    // ==========================================================
    localparam int         LRCO_ADDR_W        = 13;
    localparam logic [4:0] LRCO_INSTR_LAST    = 5'h0F;
    localparam logic [4:0] LRCO_BYTE_LAST     = 5'h07;
    localparam int         LRCO_INSTR_RD_POS  = 15;
    localparam int         LRCO_INSTR_LEN_MSB = 14;
    localparam int         LRCO_INSTR_LEN_LSB = 13;
    localparam logic [1:0] LRCO_LEN_STREAM    = 2'h3;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [12:0] LRCO_USER_CLOCK_CONFIG_TWO_ADDR = 13'h0101;
    localparam logic [7:0]  LRCO_USER_CLOCK_CONFIG_TWO_RST  = 8'h08;
    localparam logic [7:0]  LRCO_USER_CLOCK_CONFIG_TWO_MASK = 8'h0D;
    localparam logic [7:0]  LRCO_UNMAPPED_READ              = 8'h00;
    localparam int          LRCO_DETECT_EN_BIT              = 3;
    localparam int          LRCO_FORCE_RUN_BIT              = 2;
    localparam int          LRCO_PULLDOWN_DIS_BIT           = 0;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic sclk;
        logic csb_n;
        logic sdio_in;
    } lrco_spi_in_type;

    typedef struct packed {
        logic sdio_out;
        logic sdio_oe;
    } lrco_spi_out_type;

    typedef enum logic [1:0] {
        LRCO_ST_INSTR,
        LRCO_ST_DATA,
        LRCO_ST_DONE
    } lrco_spi_state_type;

    typedef struct packed {
        lrco_spi_state_type state;
        logic               sclk_prev;
        logic [15:0]        shift_in;
        logic [4:0]         bit_cnt;
        logic               rd;
        logic [1:0]         len;
        logic [1:0]         byte_cnt;
        logic [12:0]        addr;
        logic [7:0]         tx;
        logic               sdio_out;
        logic               sdio_oe;
        logic [7:0]         cfg;
        logic               osc_en;
    } lrco_state_type;

    typedef struct packed {
        logic       enc_prev;
        logic [3:0] cnt;
        logic       low_rate;
    } lrco_det_state_type;

endpackage : lrco_pkg

/* hw/lrco_rate_detect.sv */
// Encode clock low rate detector
`timescale 1ns/100ps
module lrco_rate_detect
    import lrco_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic enc_clk,
    input  wire logic enable,
    output logic      low_rate
);

    lrco_det_state_type st_reg;
    lrco_det_state_type st_next;

    always_comb begin
        st_next          = st_reg;
        st_next.enc_prev = enc_clk;
        if (!enable) begin
            // Detector off: never reports a low rate
            st_next.cnt      = 4'h0;
            st_next.low_rate = 1'b0;
        end else if (enc_clk && !st_reg.enc_prev) begin
            st_next.cnt      = 4'h0;
            st_next.low_rate = 1'b0;
        end else if (st_reg.cnt < LRCO_LOW_RATE_CYCLES) begin
            st_next.cnt = st_reg.cnt + 4'h1;
        end else begin
            // No encode edge for a full low rate period
            st_next.low_rate = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign low_rate = st_reg.low_rate;

endmodule : lrco_rate_detect

/* hw/lrco_ctrl.sv */
// Serial configuration port, clock config register and oscillator control
// What this block does
// - Detector-enable bit 3 runs below-5-MSPS detector; register resets to 0x08.
// - Detected low encode rate with detector enabled turns auxiliary oscillator on.
// - Detector-enable low disables the detector; it no longer starts oscillator.
// - Force-run bit 2 high runs the oscillator regardless of detector.
// - Bit 0 high switches off the serial data pin pull-down.
`timescale 1ns/100ps
module lrco_ctrl
    import lrco_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  lrco_spi_in_type spi_in,
    output lrco_spi_out_type spi_out,
    input  wire logic       enc_clk,
    output logic            aux_low_rate_oscillator_en,
    output logic            sdio_pulldown_en,
    output logic [7:0]      user_clock_config_two
);

    lrco_state_type st_reg;
    lrco_state_type st_next;
    logic           low_rate;
    logic           sclk_rise;
    logic           sclk_fall;
    logic [15:0]    shifted;
    logic [12:0]    addr_dec;

    // ==========================================================
    // Low rate detector
    // ==========================================================
    lrco_rate_detect u_rate_detect (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .enc_clk  (enc_clk),
        .enable   (st_reg.cfg[LRCO_DETECT_EN_BIT]),
        .low_rate (low_rate)
    );

    // ==========================================================
    // Register read mux
    // ==========================================================
    function automatic logic [7:0] read_reg(input logic [12:0] addr,
                                            input logic [7:0]  cfg);
        logic [7:0] data;
        data = LRCO_UNMAPPED_READ;
        if (addr == LRCO_USER_CLOCK_CONFIG_TWO_ADDR) begin
            data = cfg & LRCO_USER_CLOCK_CONFIG_TWO_MASK;
        end
        return data;
    endfunction : read_reg

    assign sclk_rise = spi_in.sclk && !st_reg.sclk_prev;
    assign sclk_fall = !spi_in.sclk && st_reg.sclk_prev;
    assign shifted   = {st_reg.shift_in[14:0], spi_in.sdio_in};
    assign addr_dec  = st_reg.addr - 13'h0001;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_next           = st_reg;
        st_next.sclk_prev = spi_in.sclk;

        if (spi_in.csb_n) begin
            // Chip select released: frame ends, pin released
            st_next.state    = LRCO_ST_INSTR;
            st_next.bit_cnt  = 5'h00;
            st_next.byte_cnt = 2'h0;
            st_next.sdio_oe  = 1'b0;
            st_next.sdio_out = 1'b0;
        end else begin
            unique case (st_reg.state)
                LRCO_ST_INSTR: begin
                    if (sclk_rise) begin
                        st_next.shift_in = shifted;
                        st_next.bit_cnt  = st_reg.bit_cnt + 5'h01;
                        if (st_reg.bit_cnt == LRCO_INSTR_LAST) begin
                            st_next.state    = LRCO_ST_DATA;
                            st_next.bit_cnt  = 5'h00;
                            st_next.byte_cnt = 2'h0;
                            st_next.rd       = shifted[LRCO_INSTR_RD_POS];
                            st_next.len      = shifted[LRCO_INSTR_LEN_MSB:LRCO_INSTR_LEN_LSB];
                            st_next.addr     = shifted[LRCO_ADDR_W-1:0];
                            st_next.tx       = read_reg(shifted[LRCO_ADDR_W-1:0], st_reg.cfg);
                        end
                    end
                end
                LRCO_ST_DATA: begin
                    if (sclk_fall && st_reg.rd) begin
                        // Read data leaves on falling edges, MSB first
                        st_next.sdio_oe  = 1'b1;
                        st_next.sdio_out = st_reg.tx[7];
                        st_next.tx       = {st_reg.tx[6:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        st_next.shift_in = shifted;
                        st_next.bit_cnt  = st_reg.bit_cnt + 5'h01;
                        if (st_reg.bit_cnt == LRCO_BYTE_LAST) begin
                            st_next.bit_cnt  = 5'h00;
                            st_next.byte_cnt = st_reg.byte_cnt + 2'h1;
                            st_next.addr     = addr_dec;
                            st_next.tx       = read_reg(addr_dec, st_reg.cfg);
                            if (!st_reg.rd &&
                                st_reg.addr == LRCO_USER_CLOCK_CONFIG_TWO_ADDR) begin
                                st_next.cfg = shifted[7:0] & LRCO_USER_CLOCK_CONFIG_TWO_MASK;
                            end
                            if (st_reg.len != LRCO_LEN_STREAM &&
                                st_reg.byte_cnt == st_reg.len) begin
                                st_next.state = LRCO_ST_DONE;
                            end
                        end
                    end
                end
                LRCO_ST_DONE: begin
                    // Extra clocks ignored until chip select rises
                    if (sclk_fall) begin
                        st_next.sdio_oe = 1'b0;
                    end
                end
            endcase
        end

        // Detector result or force-run bit starts the oscillator
        st_next.osc_en = st_reg.cfg[LRCO_FORCE_RUN_BIT]
                       | (st_reg.cfg[LRCO_DETECT_EN_BIT] & low_rate);
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_reg     <= '0;
            st_reg.cfg <= LRCO_USER_CLOCK_CONFIG_TWO_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign spi_out.sdio_out           = st_reg.sdio_out;
    assign spi_out.sdio_oe            = st_reg.sdio_oe;
    assign aux_low_rate_oscillator_en = st_reg.osc_en;
    assign sdio_pulldown_en           = !st_reg.cfg[LRCO_PULLDOWN_DIS_BIT];
    assign user_clock_config_two      = st_reg.cfg;

endmodule : lrco_ctrl

/* verif/lrco_chk.sv */
// Port checker for the oscillator control block
`timescale 1ns/100ps
module lrco_chk
    import lrco_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input lrco_spi_in_type  spi_in,
    input lrco_spi_out_type spi_out,
    input wire logic        enc_clk,
    input wire logic        aux_low_rate_oscillator_en,
    input wire logic        sdio_pulldown_en,
    input wire logic [7:0]  user_clock_config_two
);
    logic       enc_q;
    logic [3:0] quiet_cnt;
    wire  [7:0] cfg = user_clock_config_two;
    wire        osc = aux_low_rate_oscillator_en;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Cycles since the last sampled encode rise
    always_ff @(posedge sys_clk) begin
        enc_q <= enc_clk;
        if (!reset_n || (enc_clk && !enc_q))
            quiet_cnt <= 4'h0;
        else if (quiet_cnt != 4'hF)
            quiet_cnt <= quiet_cnt + 4'h1;
    end
    reg_reset_a: assert property ($rose(reset_n) |-> cfg == 8'h08)
        else $error("config not at reset value");
    open_bits_a: assert property ((cfg & 8'hF2) == 8'h00)
        else $error("open config bits set");
    slow_on_a: assert property ((cfg[3] && quiet_cnt > 4'h7) [*8] |-> osc)
        else $error("slow encode clock left oscillator off");
    fast_off_a: assert property ((!cfg[2] && quiet_cnt < 4'h3) [*4] |-> !osc)
        else $error("oscillator on with fast encode clock");
    det_off_a: assert property ((!cfg[3] && !cfg[2]) [*3] |-> !osc)
        else $error("oscillator on with detector disabled");
    force_on_a: assert property (cfg[2] && $past(cfg[2]) |-> osc)
        else $error("force run left oscillator off");
    pull_map_a: assert property (sdio_pulldown_en == !cfg[0])
        else $error("pull-down does not follow bit 0");
endmodule : lrco_chk
bind lrco_ctrl lrco_chk chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .spi_in(spi_in),
    .spi_out(spi_out), .enc_clk(enc_clk), .sdio_pulldown_en(sdio_pulldown_en),
    .aux_low_rate_oscillator_en(aux_low_rate_oscillator_en),
    .user_clock_config_two(user_clock_config_two));

/* verif/lrco_host.sv */
// Serial configuration host model
`timescale 1ns/100ps
module lrco_host
    import lrco_pkg::*;
(
    input  wire logic        sys_clk,
    input  lrco_spi_out_type spi_out,
    input  wire logic        sdio_pulldown_en,
    output lrco_spi_in_type  spi_in
);
    logic sclk   = 1'b0;
    logic csb_n  = 1'b1;
    logic drv    = 1'b0;
    logic drv_d  = 1'b0;
    logic last_q = 1'b0;
    logic lvl;
    // Unheld line: pull-down, else the inverse of its last level
    assign lvl = drv ? drv_d : spi_out.sdio_oe ? spi_out.sdio_out :
                 sdio_pulldown_en ? 1'b0 : ~last_q;
    assign spi_in = '{sclk: sclk, csb_n: csb_n, sdio_in: lvl};
    always @(posedge sys_clk) if (drv || spi_out.sdio_oe) last_q <= lvl;
    task automatic half;
        repeat (4) @(negedge sys_clk);
    endtask : half
    // One frame of one or two data bytes; clock and select rest between frames
    task automatic xfer(input logic rd, input logic [1:0] len, input logic [12:0] addr,
                        input logic [15:0] wd, output logic [15:0] rdat);
        logic [31:0] frm;
        int          stop;
        frm = {rd, len, addr, wd};
        stop = (len == 2'h0) ? 8 : 0;
        rdat = 16'h0000;
        csb_n = 1'b0;
        half();
        for (int i = 31; i >= stop; i--) begin
            drv = !(rd && i < 16);
            drv_d = frm[i];
            half();
            sclk = 1'b1;
            if (i < 16)
                rdat[i] = lvl;
            half();
            sclk = 1'b0;
        end
        drv = 1'b0;
        csb_n = 1'b1;
        half();
    endtask : xfer
endmodule : lrco_host

/* verif/tb_top.sv */
// Testbench for the oscillator control block
`timescale 1ns/100ps
module tb_top;
    import lrco_pkg::*;
    logic             sys_clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             enc_clk = 1'b0;
    logic             enc_run = 1'b1;
    lrco_spi_in_type  spi_in;
    lrco_spi_out_type spi_out;
    logic             osc_en;
    logic             pd_en;
    logic [7:0]       cfg;
    logic [15:0]      rd_val;
    int               fail_count = 0;
    int               n_compared = 0;
    int               cycles = 0;
    always #20 sys_clk = ~sys_clk;
    always @(negedge sys_clk) if (enc_run) enc_clk <= ~enc_clk;
    lrco_ctrl dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .spi_in(spi_in),
        .spi_out(spi_out), .enc_clk(enc_clk), .aux_low_rate_oscillator_en(osc_en),
        .sdio_pulldown_en(pd_en), .user_clock_config_two(cfg));
    lrco_host host_u (.sys_clk(sys_clk), .spi_out(spi_out), .sdio_pulldown_en(pd_en),
        .spi_in(spi_in));
    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t level %b want %b", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [15:0] dummy;
        host_u.xfer(1'b0, 2'h0, a, {d, 8'h00}, dummy);
    endtask : wr
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        host_u.xfer(1'b1, 2'h0, a, 16'h0000, rd_val);
        cmp(rd_val[15:8], exp);
    endtask : rd_chk
    // Two-byte frames: second byte goes to the next lower address
    task automatic wr2(input logic [12:0] a, input logic [15:0] d);
        logic [15:0] dummy;
        host_u.xfer(1'b0, 2'h1, a, d, dummy);
    endtask : wr2
    task automatic rd2_chk(input logic [12:0] a, input logic [15:0] exp);
        host_u.xfer(1'b1, 2'h1, a, 16'h0000, rd_val);
        cmp(rd_val[15:8], exp[15:8]);
        cmp(rd_val[7:0], exp[7:0]);
    endtask : rd2_chk
    // Run or stop the encode clock, then check the oscillator
    task automatic osc_chk(input logic run, input logic exp);
        enc_run = run;
        repeat (20) @(negedge sys_clk);
        cmp_bit(osc_en, exp);
    endtask : osc_chk
    initial begin
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        cmp(cfg, 8'h08);
        cmp_bit(pd_en, 1'b1);
        rd_chk(13'h0101, 8'h08);
        $display("test reset done");
        osc_chk(1'b1, 1'b0);
        osc_chk(1'b0, 1'b1);
        osc_chk(1'b1, 1'b0);
        wr(13'h0101, 8'h00);
        osc_chk(1'b0, 1'b0);
        $display("test detector done");
        wr(13'h0101, 8'h04);
        osc_chk(1'b0, 1'b1);
        osc_chk(1'b1, 1'b1);
        rd_chk(13'h0101, 8'h04);
        $display("test force run done");
        wr(13'h0101, 8'hFF);
        rd_chk(13'h0101, 8'h0D);
        cmp_bit(pd_en, 1'b0);
        wr(13'h0100, 8'h00);
        rd_chk(13'h0100, 8'h00);
        rd_chk(13'h0101, 8'h0D);
        wr2(13'h0102, 16'hFF09);
        rd2_chk(13'h0102, 16'h0009);
        osc_chk(1'b0, 1'b1);
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        cmp(cfg, 8'h08);
        cmp_bit(pd_en, 1'b1);
        cmp_bit(osc_en, 1'b0);
        rd_chk(13'h0101, 8'h08);
        $display("test map and reset done");
        close_out();
    end
endmodule : tb_top
